// ==== verilog/scqs_pkg.sv ====
// constants, register map and types for the solar charge quick start control
package scqs_pkg;

   // clock and timebase
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned TICK_MS      = 250;      // quarter-second timebase step
   localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

   // event times in milliseconds, and as timebase steps
   localparam int unsigned SAMPLE_MS    = 2000;     // comparator sampling period
   localparam int unsigned QS_RESET_MS  = 16000;    // periodic quick start reset
   localparam int unsigned OSC_DELAY_MS = 1000;     // reset delay after oscillation seen
   localparam int unsigned WAKE_1ST_MS  = 1000;     // first wakeup, 0.75 to 1 s after charge
   localparam int unsigned WAKE_REP_MS  = 2000;     // wakeup repeat period
   localparam int unsigned SAMPLE_Q     = SAMPLE_MS / TICK_MS;
   localparam int unsigned QS_RESET_Q   = QS_RESET_MS / TICK_MS;
   localparam int unsigned OSC_DELAY_Q  = OSC_DELAY_MS / TICK_MS;
   localparam int unsigned WAKE_1ST_Q   = WAKE_1ST_MS / TICK_MS;
   localparam int unsigned WAKE_REP_Q   = WAKE_REP_MS / TICK_MS;

   // register byte offsets
   localparam logic [7:0] OFF_STATUS    = 8'h00;
   localparam logic [7:0] OFF_MASK      = 8'h04;
   localparam logic [7:0] OFF_MONITOR   = 8'h08;
   localparam logic [7:0] OFF_LIMITER   = 8'h0C;

   // status field positions
   localparam int unsigned BIT_WAKE     = 0;
   localparam int unsigned BIT_RECHARGE = 1;
   localparam int unsigned BIT_QS_B     = 2;
   localparam int unsigned BIT_QS_A     = 3;
   // monitor enable field positions
   localparam int unsigned BIT_MON_RCH  = 0;
   localparam int unsigned BIT_MON_QSB  = 1;
   localparam int unsigned BIT_MON_QSA  = 2;

   // reset values
   localparam logic        RST_WAKE_MASK = 1'b0;
   localparam logic [2:0]  RST_MON_EN    = 3'h0;
   localparam int unsigned LIMIT_OPT_DEF = 1;

   // quick start states: normal, both flags set, flag a cleared
   typedef enum logic [2:0] {
      QS_NORMAL = 3'b001,
      QS_FULL   = 3'b010,
      QS_HALF   = 3'b100
   } scqs_state_t;

   // limiter on voltage in millivolts for mask option 1 to 9
   function automatic logic [11:0] scqs_limit_mv(input logic [3:0] opt);
      logic [11:0] mv;
      mv = 12'h834;
      case (opt)
         4'h2: mv = 12'h9C4;
         4'h3: mv = 12'hA28;
         4'h4: mv = 12'hA8C;
         4'h5: mv = 12'hAF0;
         4'h6: mv = 12'hB54;
         4'h7: mv = 12'hBB8;
         4'h8: mv = 12'hC1C;
         4'h9: mv = 12'hC80;
         default: mv = 12'h834;
      endcase
      return mv;
   endfunction

   // true when a step counter sits on its last step of a period
   function automatic logic scqs_last(input logic [6:0] cnt, input int unsigned period);
      return cnt == 7'(period - 1);
   endfunction

endpackage

// ==== verilog/scqs_ctrl.sv ====
// solar charge tracking, quick start sequencer and wakeup flag with ahb-lite registers
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns

module scqs_ctrl #(
   parameter int unsigned TICK_CYCLES = scqs_pkg::TICK_CYCLES,
   parameter logic [3:0]  LIMIT_OPT   = 4'(scqs_pkg::LIMIT_OPT_DEF)
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // analog side
   input  wire logic        solar_cmp,
   input  wire logic        negation_cmp,
   input  wire logic        limiter_cmp,
   input  wire logic        osc_detect,
   input  wire logic        qs_entry,
   output logic [11:0]      limiter_level_mv,
   output logic             limiter_on,
   output logic             qs_reset_pulse,
   output logic             wakeup_irq,
   // monitor terminals
   output logic             recharge_monitor_terminal,
   output logic             quick_start_b_monitor_terminal,
   output logic             quick_start_a_monitor_terminal
);

   localparam int unsigned CNT_W = $clog2(TICK_CYCLES);

   // synchroniser stages for the asynchronous inputs
   logic [3:0]  sync1_reg;
   logic [3:0]  sync2_reg;
   logic        osc_prev_reg;
   wire  logic  solar_s    = sync2_reg[0];
   wire  logic  negation_s = sync2_reg[1];
   wire  logic  limiter_s  = sync2_reg[2];
   wire  logic  osc_s      = sync2_reg[3];
   wire  logic  osc_rise   = osc_s & ~osc_prev_reg;

   // timebase and period counters
   logic [CNT_W-1:0] tick_cnt_reg;
   logic             tick_reg;
   logic [6:0]       samp_q_reg;
   logic [6:0]       qs_q_reg;
   logic [6:0]       osc_q_reg;
   logic             osc_arm_reg;
   logic [6:0]       wk_q_reg;
   logic             wk_first_reg;

   // flags and state
   scqs_pkg::scqs_state_t state_reg;
   scqs_pkg::scqs_state_t state_next;
   logic                  recharge_flag_reg;
   logic                  wakeup_flag_reg;
   logic                  limiter_status_reg;
   logic                  qs_reset_reg;
   logic                  wakeup_mask_reg;
   logic [2:0]            mon_en_reg;
   logic [2:0]            term_reg;

   // bus registers
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic [31:0] rdata_reg;

   // quick start flags decoded from state
   // flag b stays up through the half state, flag a only in the full one
   wire logic in_qs              = state_reg != scqs_pkg::QS_NORMAL;
   wire logic quick_start_flag_a = state_reg == scqs_pkg::QS_FULL;
   wire logic quick_start_flag_b = in_qs;

   // comparator sample strobe every two seconds
   wire logic sample = tick_reg & scqs_pkg::scqs_last(samp_q_reg, scqs_pkg::SAMPLE_Q);
   wire logic neg_sample = sample & in_qs;

   // periodic and oscillation-triggered quick start resets
   // the delayed reset only counts once an oscillation rise has armed it
   wire logic qs_per_hit = in_qs & tick_reg
                         & scqs_pkg::scqs_last(qs_q_reg, scqs_pkg::QS_RESET_Q);
   wire logic osc_hit    = in_qs & osc_arm_reg & tick_reg
                         & scqs_pkg::scqs_last(osc_q_reg, scqs_pkg::OSC_DELAY_Q);
   wire logic qs_rst_now = qs_per_hit | osc_hit;

   // wakeup event timing
   // first period four steps, then eight, while the recharge flag is up
   wire logic wk_period  = wk_first_reg ? scqs_pkg::scqs_last(wk_q_reg, scqs_pkg::WAKE_REP_Q)
                                        : scqs_pkg::scqs_last(wk_q_reg, scqs_pkg::WAKE_1ST_Q);
   wire logic wake_event = recharge_flag_reg & tick_reg & wk_period;

   // one-hot register select, shared by read and write decode
   function automatic logic [3:0] reg_sel(input logic [7:0] addr);
      logic [3:0] sel;
      case (addr)
         scqs_pkg::OFF_STATUS:  sel = 4'h1;
         scqs_pkg::OFF_MASK:    sel = 4'h2;
         scqs_pkg::OFF_MONITOR: sel = 4'h4;
         scqs_pkg::OFF_LIMITER: sel = 4'h8;
         default:               sel = 4'h0;
      endcase
      return sel;
   endfunction

   // ahb address phase decode; hsize is ignored, every access is a whole word
   wire logic       addr_ok = hsel & htrans[1] & hready;
   wire logic       rd_go   = addr_ok & ~hwrite;
   wire logic       wr_go   = addr_ok & hwrite;
   wire logic [3:0] rd_sel  = reg_sel(haddr);
   wire logic [3:0] wr_sel  = reg_sel(wr_addr_reg);
   wire logic       wr_stat = wr_pend_reg & wr_sel[0];
   wire logic       wr_mask = wr_pend_reg & wr_sel[1];
   wire logic       wr_mon  = wr_pend_reg & wr_sel[2];
   wire logic       wk_clr  = wr_stat & hwdata[scqs_pkg::BIT_WAKE];

   // read data selection; the wakeup flag is the only status flag with a write path
   wire logic [31:0] stat_word = {28'h0000000, quick_start_flag_a, quick_start_flag_b,
                                  recharge_flag_reg, wakeup_flag_reg};
   wire logic [31:0] mask_word = {31'h00000000, wakeup_mask_reg};
   wire logic [31:0] mon_word  = {29'h00000000, mon_en_reg};
   wire logic [31:0] lim_word  = {31'h00000000, limiter_status_reg};
   wire logic [31:0] rd_word   = rd_sel[0] ? stat_word :
                                 rd_sel[1] ? mask_word :
                                 rd_sel[2] ? mon_word  :
                                 rd_sel[3] ? lim_word  :
                                 32'h00000000;

   // two flip-flop synchronisers
   // comparators move at any time against clk; only stage two feeds logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg    <= 4'h0;
         sync2_reg    <= 4'h0;
         osc_prev_reg <= 1'b0;
      end else begin
         sync1_reg    <= {osc_detect, limiter_cmp, negation_cmp, solar_cmp};
         sync2_reg    <= sync1_reg;
         osc_prev_reg <= osc_s;
      end
   end

   // quarter-second timebase
   // tick is registered so every period counter sees one clean strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else begin
         tick_reg     <= tick_cnt_reg == CNT_W'(TICK_CYCLES - 1);
         tick_cnt_reg <= (tick_cnt_reg == CNT_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt_reg + 1'b1;
      end
   end

   // two-second sampling step counter
   // both thresholds share this strobe, so they are never compared apart
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         samp_q_reg <= 7'h00;
      end else if (tick_reg) begin
         samp_q_reg <= sample ? 7'h00 : samp_q_reg + 7'h01;
      end
   end

   // recharge flag tracks the synchronised comparator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         recharge_flag_reg <= 1'b0;
      end else begin
         recharge_flag_reg <= solar_s;
      end
   end

   // quick start next state
   // a low sample after flag a has cleared breaks the succession
   // and returns to the full quick start state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         scqs_pkg::QS_NORMAL: state_next = scqs_pkg::QS_NORMAL;
         scqs_pkg::QS_FULL: begin
            if (neg_sample && negation_s) begin
               state_next = scqs_pkg::QS_HALF;
            end
         end
         scqs_pkg::QS_HALF: begin
            if (neg_sample) begin
               state_next = negation_s ? scqs_pkg::QS_NORMAL : scqs_pkg::QS_FULL;
            end
         end
      endcase
      if (qs_entry) begin
         state_next = scqs_pkg::QS_FULL;
      end
   end

   // quick start state; the reset pin lands in normal mode
   // only qs_entry, never rst_n, can lead into quick start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= scqs_pkg::QS_NORMAL;
      end else begin
         state_reg <= state_next;
      end
   end

   // sixteen-second reset period counter
   // restarts on entry and on every request, the delayed one included
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qs_q_reg <= 7'h00;
      end else if (!in_qs || qs_entry || qs_rst_now) begin
         qs_q_reg <= 7'h00;
      end else if (tick_reg) begin
         qs_q_reg <= qs_q_reg + 7'h01;
      end
   end

   // one-second delay after oscillation is detected
   // a rise seen in normal mode is ignored, so no reset escapes there
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_arm_reg <= 1'b0;
         osc_q_reg   <= 7'h00;
      end else if (osc_rise && in_qs) begin
         osc_arm_reg <= 1'b1;
         osc_q_reg   <= 7'h00;
      end else if (!in_qs || osc_hit) begin
         osc_arm_reg <= 1'b0;
         osc_q_reg   <= 7'h00;
      end else if (osc_arm_reg && tick_reg) begin
         osc_q_reg   <= osc_q_reg + 7'h01;
      end
   end

   // internal reset pulse, one clock wide
   // registered so the request cannot glitch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qs_reset_reg <= 1'b0;
      end else begin
         qs_reset_reg <= qs_rst_now;
      end
   end

   // limiter follows each sample of its comparator
   // between strobes the status holds even if the battery moves
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         limiter_status_reg <= 1'b0;
      end else if (sample) begin
         limiter_status_reg <= limiter_s;
      end
   end

   // wakeup period counter, restarted whenever charging stops
   // four steps to the first event lands 0.75 to 1 s after the flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wk_q_reg     <= 7'h00;
         wk_first_reg <= 1'b0;
      end else if (!recharge_flag_reg) begin
         wk_q_reg     <= 7'h00;
         wk_first_reg <= 1'b0;
      end else if (tick_reg) begin
         wk_q_reg     <= wk_period ? 7'h00 : wk_q_reg + 7'h01;
         wk_first_reg <= wk_first_reg | wk_period;
      end
   end

   // wakeup flag: a new event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeup_flag_reg <= 1'b0;
      end else if (wake_event) begin
         wakeup_flag_reg <= 1'b1;
      end else if (wk_clr) begin
         wakeup_flag_reg <= 1'b0;
      end
   end

   // software-written mask and monitor enables
   // reset values leave every terminal low and the interrupt masked
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeup_mask_reg <= scqs_pkg::RST_WAKE_MASK;
         mon_en_reg      <= scqs_pkg::RST_MON_EN;
      end else begin
         if (wr_mask) begin
            wakeup_mask_reg <= hwdata[0];
         end
         if (wr_mon) begin
            mon_en_reg <= hwdata[2:0];
         end
      end
   end

   // monitor terminals: flag when enabled, low otherwise
   // registered so a pin never glitches while a flag and its enable move
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         term_reg <= 3'h0;
      end else begin
         term_reg[scqs_pkg::BIT_MON_RCH] <= mon_en_reg[scqs_pkg::BIT_MON_RCH]
                                          & recharge_flag_reg;
         term_reg[scqs_pkg::BIT_MON_QSB] <= mon_en_reg[scqs_pkg::BIT_MON_QSB]
                                          & quick_start_flag_b;
         term_reg[scqs_pkg::BIT_MON_QSA] <= mon_en_reg[scqs_pkg::BIT_MON_QSA]
                                          & quick_start_flag_a;
      end
   end

   // ahb data phase: latch write target, register read data
   // read data is taken in the address phase, so a read right after
   // a write to the same word still returns the old value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg   <= 32'h00000000;
      end else begin
         wr_pend_reg <= wr_go;
         wr_addr_reg <= haddr;
         if (rd_go) begin
            rdata_reg <= rd_word;
         end
      end
   end

   // outputs
   // the slave never stalls and always answers okay
   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign hrdata           = rdata_reg;
   assign limiter_level_mv = scqs_pkg::scqs_limit_mv(LIMIT_OPT);
   assign limiter_on       = limiter_status_reg;
   assign qs_reset_pulse   = qs_reset_reg;
   assign wakeup_irq       = wakeup_flag_reg & wakeup_mask_reg;
   assign recharge_monitor_terminal      = term_reg[scqs_pkg::BIT_MON_RCH];
   assign quick_start_b_monitor_terminal = term_reg[scqs_pkg::BIT_MON_QSB];
   assign quick_start_a_monitor_terminal = term_reg[scqs_pkg::BIT_MON_QSA];

endmodule

// ==== dv/scqs_properties.sv ====
// port-level assertions for the solar charge quick start control
`timescale 1ns/1ns
module scqs_properties #(
   parameter int unsigned TICK_CYCLES = 10
) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        qs_entry,
   input wire logic [11:0] limiter_level_mv,
   input wire logic        qs_reset_pulse,
   input wire logic        wakeup_irq,
   input wire logic        recharge_monitor_terminal,
   input wire logic        quick_start_b_monitor_terminal
);
   logic        ap_wr;
   logic [7:0]  ap_a;
   logic        mask_q;
   logic [2:0]  mon_q;
   int unsigned rst_cnt;
   int unsigned wk_cnt;
   // shadow of mask and monitor writes, plus wait counters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_wr   <= 1'b0;
         ap_a    <= 8'h00;
         mask_q  <= 1'b0;
         mon_q   <= 3'h0;
         rst_cnt <= 0;
         wk_cnt  <= 0;
      end else begin
         ap_wr   <= hsel && htrans[1] && hready && hwrite;
         ap_a    <= haddr;
         if (ap_wr && ap_a == 8'h04) mask_q <= hwdata[0];
         if (ap_wr && ap_a == 8'h08) mon_q <= hwdata[2:0];
         rst_cnt <= (qs_reset_pulse || qs_entry) ? 0 : rst_cnt + 1;
         wk_cnt  <= (recharge_monitor_terminal && mon_q[0] && mask_q && !wakeup_irq) ? wk_cnt + 1 : 0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // entry raises flag b two edges later on its terminal
   sequence s_entry_seen;
      qs_entry && mon_q[1];
   endsequence
   sequence s_flag_b_up;
      ##2 quick_start_b_monitor_terminal;
   endsequence
   a_entry_flags: assert property (s_entry_seen |-> s_flag_b_up)
      else $error("quick start flag b not raised after entry");
   a_pulse_single: assert property (qs_reset_pulse |=> !qs_reset_pulse)
      else $error("reset request longer than one cycle");
   a_reset_period: assert property (quick_start_b_monitor_terminal && mon_q[1] |-> rst_cnt < 64 * TICK_CYCLES + 8)
      else $error("periodic reset missing in quick start");
   a_no_pulse_normal: assert property (qs_reset_pulse && mon_q[1] |-> quick_start_b_monitor_terminal)
      else $error("reset request outside quick start");
   a_irq_mask: assert property (wakeup_irq |-> mask_q)
      else $error("wakeup interrupt while masked");
   a_wake_period: assert property (wk_cnt < 8 * TICK_CYCLES + 8)
      else $error("wakeup flag not raised while charging");
   a_term_low: assert property (!mon_q[0] [*2] |-> !recharge_monitor_terminal)
      else $error("disabled monitor terminal not low");
   a_level_fixed: assert property ($stable(limiter_level_mv))
      else $error("limiter level changed");
endmodule
bind scqs_ctrl scqs_properties #(.TICK_CYCLES(TICK_CYCLES)) u_scqs_properties (.clk, .rst_n, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .qs_entry, .limiter_level_mv, .qs_reset_pulse, .wakeup_irq,
   .recharge_monitor_terminal, .quick_start_b_monitor_terminal);

// ==== dv/scqs_analog.sv ====
// analog comparators and oscillation detector beside the charge control
`timescale 1ns/1ns
module scqs_analog (
   input  wire logic [11:0] batt_mv,
   input  wire logic        solar_hi,
   input  wire logic        osc_seen,
   input  wire logic [11:0] limit_mv,
   output logic             solar_cmp,
   output logic             negation_cmp,
   output logic             limiter_cmp,
   output logic             osc_detect
);
   // comparators settle a few ns after the sensed level moves
   assign #3 solar_cmp    = solar_hi;
   assign #3 negation_cmp = batt_mv >= 12'h3E8;
   assign #3 limiter_cmp  = batt_mv >= limit_mv;
   assign #3 osc_detect   = osc_seen;
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the solar charge quick start control
`timescale 1ns/1ns
module testbench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        qs_entry = 1'b0;
   logic [11:0] batt_mv = 12'h1F4;
   logic        solar_hi = 1'b0;
   logic        osc_seen = 1'b0;
   logic        hreadyout, hresp, limiter_on, qs_reset_pulse, wakeup_irq;
   logic        solar_cmp, negation_cmp, limiter_cmp, osc_detect, t_rch, t_qsb, t_qsa;
   logic [31:0] hrdata, rd;
   logic [11:0] level_mv;
   int          n_fail = 0, num_checks = 0, cnt, k;
   int          m_wake = 0, m_rch = 0, m_qsa = 0, m_qsb = 0, m_mask = 0;
   int          mons[$];
   always #20 clk = ~clk;
   scqs_ctrl #(.TICK_CYCLES(10), .LIMIT_OPT(4'h1)) u_scqs_ctrl (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .solar_cmp, .negation_cmp, .limiter_cmp,
      .osc_detect, .qs_entry, .limiter_level_mv(level_mv), .limiter_on, .qs_reset_pulse, .wakeup_irq,
      .recharge_monitor_terminal(t_rch), .quick_start_b_monitor_terminal(t_qsb),
      .quick_start_a_monitor_terminal(t_qsa));
   scqs_analog u_scqs_analog (.batt_mv, .solar_hi, .osc_seen, .limit_mv(level_mv), .solar_cmp, .negation_cmp,
      .limiter_cmp, .osc_detect);
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one single-word transfer, holding each phase until ready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // model view of the status word
   function automatic logic [31:0] st();
      return {28'h0, m_qsa[0], m_qsb[0], m_rch[0], m_wake[0]};
   endfunction
   // count reset requests over n cycles
   task automatic count_pulses(input int n);
      cnt = 0;
      for (k = 0; k < n; k++) begin
         @(posedge clk);
         if (qs_reset_pulse === 1'b1) cnt++;
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #(40 * 20000);
      n_fail++;
      end_of_test();
   end
   // main sequence; register access, quick start, then charging and wakeup
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      void'($urandom(32'h60bf));
      for (int i = 0; i < 5; i++) rdchk(8'(i * 4), 32'h0);
      chk(level_mv, 32'h834);
      m_mask = 1;
      bus(1'b1, 8'h04, 32'h1);
      bus(1'b1, 8'h08, 32'h7);
      bus(1'b1, 8'h00, 32'hE);
      bus(1'b1, 8'h10, $urandom);
      chk({hreadyout, hresp}, 32'h2);
      rdchk(8'h04, m_mask);
      rdchk(8'h08, 32'h7);
      rdchk(8'h00, st());
      rdchk(8'h10, 32'h0);
      // quick start entry, periodic and delayed resets
      @(posedge clk) qs_entry <= 1'b1;
      @(posedge clk) qs_entry <= 1'b0;
      m_qsa = 1;
      m_qsb = 1;
      rdchk(8'h00, st());
      chk({t_qsa, t_qsb, t_rch}, 3'b110);
      count_pulses(700);
      chk(cnt, 1);
      osc_seen <= 1'b1;
      for (cnt = 0; cnt < 60 && qs_reset_pulse !== 1'b1; cnt++) @(posedge clk);
      chk(cnt >= 25 && cnt <= 46, 1);
      osc_seen <= 1'b0;
      // a good sample clears flag a
      batt_mv <= 12'h9C4;
      for (cnt = 0; cnt < 200 && limiter_on !== 1'b1; cnt++) @(posedge clk);
      chk(limiter_on, 1'b1);
      m_qsa = 0;
      rdchk(8'h00, st());
      rdchk(8'h0C, 32'h1);
      // a low sample after flag a cleared breaks the succession
      batt_mv <= 12'h1F4;
      for (cnt = 0; cnt < 200 && limiter_on !== 1'b0; cnt++) @(posedge clk);
      chk(limiter_on, 1'b0);
      m_qsa = 1;
      rdchk(8'h00, st());
      batt_mv <= 12'h9C4;
      for (cnt = 0; cnt < 200 && limiter_on !== 1'b1; cnt++) @(posedge clk);
      m_qsa = 0;
      rdchk(8'h00, st());
      batt_mv <= 12'h5DC;
      for (cnt = 0; cnt < 200 && limiter_on !== 1'b0; cnt++) @(posedge clk);
      chk(limiter_on, 1'b0);
      m_qsb = 0;
      rdchk(8'h00, st());
      rdchk(8'h0C, 32'h0);
      batt_mv <= 12'h1F4;
      count_pulses(700);
      chk(cnt, 0);
      rdchk(8'h00, st());
      // charging, wakeup flag, mask and clear
      solar_hi <= 1'b1;
      repeat (6) @(posedge clk);
      m_rch = 1;
      rdchk(8'h00, st());
      for (cnt = 0; cnt < 60 && wakeup_irq !== 1'b1; cnt++) @(posedge clk);
      chk(wakeup_irq, 1'b1);
      m_wake = 1;
      rdchk(8'h00, st());
      bus(1'b1, 8'h00, 32'h1);
      m_wake = 0;
      rdchk(8'h00, st());
      chk(wakeup_irq, 1'b0);
      bus(1'b1, 8'h04, 32'h0);
      m_mask = 0;
      repeat (100) @(posedge clk);
      m_wake = 1;
      rdchk(8'h00, st());
      chk(wakeup_irq, 1'b0);
      for (int i = 0; i < 4; i++) mons.push_back($urandom % 8);
      foreach (mons[i]) begin
         bus(1'b1, 8'h08, mons[i]);
         repeat (2) @(posedge clk);
         chk({t_qsa, t_qsb, t_rch}, 3'(mons[i]) & {m_qsa[0], m_qsb[0], m_rch[0]});
      end
      solar_hi <= 1'b0;
      repeat (10) @(posedge clk);
      m_rch = 0;
      bus(1'b1, 8'h00, 32'h1);
      m_wake = 0;
      rdchk(8'h00, st());
      end_of_test();
   end
endmodule
